// [core/lpc_awu_timer.v]
// Auto-wakeup timer: prescaled slow-oscillator tick counter with window match.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module lpc_awu_timer (
	input wire aclk, // System clock.
	input wire aresetn, // Synchronous reset, active low.
	input wire enable, // Timer runs while high.
	input wire slow_tick, // One pulse per slow oscillator period.
	input wire [`LPC_W_PSC-1:0] psc, // Divide slow ticks by two to this power.
	input wire [`LPC_W_WIN-1:0] window, // Match value of the count.
	output reg wake_event // One-cycle wake pulse.
);
	reg [`LPC_W_PCNT-1:0] pcnt;
	reg [`LPC_W_WIN-1:0] count;
	wire [`LPC_W_PCNT-1:0] plimit;
	wire ptick;

	assign plimit = (16'h0001 << psc) - 16'h0001;
	assign ptick = slow_tick && (pcnt == plimit);

	// count prescaled ticks
	// A disabled timer restarts from zero so the first period is whole.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pcnt <= 16'h0000;
			count <= 6'h00;
			wake_event <= 1'b0;
		end else if (!enable) begin
			pcnt <= 16'h0000;
			count <= 6'h00;
			wake_event <= 1'b0;
		end else begin
			wake_event <= 1'b0;
			if (slow_tick) begin
				pcnt <= ptick ? 16'h0000 : pcnt + 16'h0001;
			end
			if (ptick) begin
				if (count == window) begin
					count <= 6'h00;
					wake_event <= 1'b1;
				end else begin
					count <= count + 6'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [core/lpc_controller.v]
// Low-power mode controller: sleep and standby sequencing with AXI4-Lite registers.
//
// How it works
// - Reset starts in run, no low-power mode.
// - Exactly two modes: sleep and standby.
// - Sleep stops core clock only, regulator on.
// - Deep 0, standby 0, wait instr: sleep.
// - Deep 1, standby 1, wait instr: standby.
// - Standby gates fast oscillators, PLL, peripherals, regulator.
// - Standby keeps SRAM, registers, pin states.
// - Standby wake selects internal fast oscillator, no reset.
// - Flash programming delays standby entry.
// - Watchdog and slow oscillator keep running.
// - Interrupt wakes wait-for-interrupt; handler runs first.
// - Event-mode line wakes wait-for-event.
// - Pending-wake enable lets peripheral interrupts wake.
// - Sleep-after-exit waits for handlers to return.
// - Pending-wakes-event lets any interrupt end wait-for-event.
// - Sleep keeps pins, peripheral clocks; fastest wake.
// - Auto-wakeup timer on slow oscillator wakes standby.
// - Auto-wakeup drives event line nine.
// - Event unit sources or auto-wakeup end standby.
// - Window resets to 3F, others to zero.
// - With deep sleep set, standby select set chooses standby, else sleep.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module lpc_controller (
	input wire aclk, // System clock, 125 MHz.
	input wire aresetn, // Synchronous reset, active low.
	input wire [31:0] s_axi_awaddr, // Write address.
	input wire s_axi_awvalid, // Write address valid.
	output reg s_axi_awready, // Write address ready.
	input wire [31:0] s_axi_wdata, // Write data.
	input wire [3:0] s_axi_wstrb, // Write byte strobes.
	input wire s_axi_wvalid, // Write data valid.
	output reg s_axi_wready, // Write data ready.
	output reg [1:0] s_axi_bresp, // Write response.
	output reg s_axi_bvalid, // Write response valid.
	input wire s_axi_bready, // Write response ready.
	input wire [31:0] s_axi_araddr, // Read address.
	input wire s_axi_arvalid, // Read address valid.
	output reg s_axi_arready, // Read address ready.
	output reg [31:0] s_axi_rdata, // Read data.
	output reg [1:0] s_axi_rresp, // Read response.
	output reg s_axi_rvalid, // Read data valid.
	input wire s_axi_rready, // Read data ready.
	input wire wait_for_interrupt_instr, // Core executes a wait-for-interrupt.
	input wire wait_for_event_instr, // Core executes a wait-for-event.
	input wire handler_active, // Interrupt handlers still pending.
	input wire irq_accepted, // Interrupt taken by the controller.
	input wire periph_irq_pending, // Peripheral-only interrupt pending.
	input wire event_line_event, // Event-mode line fired.
	input wire event_line_wake, // Enabled line in the event unit fired.
	input wire flash_busy, // Flash programming in progress.
	input wire internal_slow_osc, // Slow oscillator, asynchronous.
	output reg core_clk_en, // Core clock enable.
	output reg periph_clk_en, // Peripheral clock enable.
	output reg internal_fast_osc_en, // Internal fast oscillator enable.
	output reg external_fast_osc_en, // External fast oscillator enable.
	output reg pll_en, // PLL enable.
	output reg regulator_low_power, // Regulator in low-power state.
	output reg state_retain, // Hold SRAM, registers and pins.
	output reg internal_slow_osc_en, // Slow oscillator enable.
	output reg watchdog_clk_en, // Independent watchdog clock enable.
	output reg sysclk_to_fast_internal, // Pulse: select internal fast osc.
	output reg irq_service_first, // Pulse: run the waking handler first.
	output reg awu_event_line9, // Pulse to event line nine.
	output reg low_power_active // Sleep or standby in force.
);
	// Mode states.
	localparam [2:0] ST_RUN = 3'b000;
	localparam [2:0] ST_HOLD = 3'b001;
	localparam [2:0] ST_FLASH = 3'b010;
	localparam [2:0] ST_SLEEP = 3'b011;
	localparam [2:0] ST_STBY = 3'b100;
	localparam [2:0] ST_WAKE = 3'b101;

	reg [2:0] state;
	reg [2:0] next_state;
	reg go_stby;
	reg wait_is_wfe;

	reg standby_select;
	reg awu_enable;
	reg [`LPC_W_WIN-1:0] awu_window;
	reg [`LPC_W_PSC-1:0] awu_psc;
	reg deep_sleep_select;
	reg sleep_after_handler_exit;
	reg pending_wakes_event;
	reg pending_wake_enable;

	reg [31:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg aw_hold;
	reg w_hold;
	reg [31:0] rd_mux;
	reg rd_ok;
	reg wr_ok;

	wire wr_fire;
	wire wr_lane0;
	wire wait_instr;
	wire tgt_stby;
	wire slow_sync;
	reg slow_prev;
	wire slow_tick;
	wire awu_wake;
	wire periph_wake;
	reg wake;

	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
	assign wr_lane0 = wr_fire && w_strb[0];
	assign wait_instr = wait_for_interrupt_instr || wait_for_event_instr;
	assign tgt_stby = deep_sleep_select && standby_select;

	// The slow oscillator is another clock; only its synchronised copy is read.
	lpc_sync2 #(
		.W(1)
	) u_slow_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(internal_slow_osc),
		.sync_out(slow_sync)
	);

	// Rising edges of the slow oscillator become one-cycle ticks.
	always @(posedge aclk) begin
		if (!aresetn) begin
			slow_prev <= 1'b0;
		end else begin
			slow_prev <= slow_sync;
		end
	end
	assign slow_tick = slow_sync && !slow_prev;

	lpc_awu_timer u_awu (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(awu_enable),
		.slow_tick(slow_tick),
		.psc(awu_psc),
		.window(awu_window),
		.wake_event(awu_wake)
	);

	// Write channel: address and data are taken in either order, then applied.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LPC_RESP_OK;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= `LPC_RST_ZERO;
			w_data <= `LPC_RST_ZERO;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_hold <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_hold <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `LPC_RESP_OK : `LPC_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Writable addresses; the status registers answer an error on write.
	always @* begin
		if (aw_addr == `LPC_A_CTRL) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `LPC_A_AWCTL) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `LPC_A_AWWIN) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `LPC_A_AWPSC) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `LPC_A_CFG) begin
			wr_ok = 1'b1;
		end else begin
			wr_ok = 1'b0;
		end
	end

	// Register storage. Only byte lane 0 holds bits; upper lanes are ignored.
	// reset values
	always @(posedge aclk) begin
		if (!aresetn) begin
			standby_select <= 1'b0;
			awu_enable <= 1'b0;
			awu_window <= `LPC_RST_WIN;
			awu_psc <= `LPC_RST_PSC;
			deep_sleep_select <= 1'b0;
			sleep_after_handler_exit <= 1'b0;
			pending_wakes_event <= 1'b0;
			pending_wake_enable <= 1'b0;
		end else if (wr_lane0) begin
			if (aw_addr == `LPC_A_CTRL) begin
				standby_select <= w_data[`LPC_B_STBY];
			end else if (aw_addr == `LPC_A_AWCTL) begin
				awu_enable <= w_data[`LPC_B_AWEN];
			end else if (aw_addr == `LPC_A_AWWIN) begin
				awu_window <= w_data[`LPC_W_WIN-1:0];
			end else if (aw_addr == `LPC_A_AWPSC) begin
				awu_psc <= w_data[`LPC_W_PSC-1:0];
			end else if (aw_addr == `LPC_A_CFG) begin
				deep_sleep_select <= w_data[`LPC_B_DEEP];
				sleep_after_handler_exit <= w_data[`LPC_B_EXIT];
				pending_wakes_event <= w_data[`LPC_B_SEVP];
				pending_wake_enable <= w_data[`LPC_B_PWEN];
			end
		end
	end

	// Read multiplexer; reserved bits read as zero.
	always @* begin
		rd_mux = `LPC_RST_ZERO;
		rd_ok = 1'b1;
		if (s_axi_araddr == `LPC_A_CTRL) begin
			rd_mux[`LPC_B_STBY] = standby_select;
		end else if (s_axi_araddr == `LPC_A_STAT) begin
			rd_mux = `LPC_RST_ZERO;
		end else if (s_axi_araddr == `LPC_A_AWCTL) begin
			rd_mux[`LPC_B_AWEN] = awu_enable;
		end else if (s_axi_araddr == `LPC_A_AWWIN) begin
			rd_mux[`LPC_W_WIN-1:0] = awu_window;
		end else if (s_axi_araddr == `LPC_A_AWPSC) begin
			rd_mux[`LPC_W_PSC-1:0] = awu_psc;
		end else if (s_axi_araddr == `LPC_A_CFG) begin
			rd_mux[`LPC_B_DEEP] = deep_sleep_select;
			rd_mux[`LPC_B_EXIT] = sleep_after_handler_exit;
			rd_mux[`LPC_B_SEVP] = pending_wakes_event;
			rd_mux[`LPC_B_PWEN] = pending_wake_enable;
		end else if (s_axi_araddr == `LPC_A_MODE) begin
			rd_mux[`LPC_W_ST-1:0] = state;
			rd_mux[`LPC_B_TGT] = go_stby;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read channel: one read at a time, data registered one cycle later.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `LPC_RST_ZERO;
			s_axi_rresp <= `LPC_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? `LPC_RESP_OK : `LPC_RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	assign periph_wake = periph_irq_pending &&
		(pending_wake_enable || (wait_is_wfe && pending_wakes_event));

	// Wake sources depend on the instruction that entered and on the mode.
	always @* begin
		wake = irq_accepted || periph_wake;
		if (wait_is_wfe) begin
			wake = wake || event_line_event;
		end
		if (state == ST_STBY) begin
			wake = wake || event_line_wake || awu_wake;
		end
	end

	// Mode sequencer.
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (wait_instr) begin
					if (sleep_after_handler_exit && handler_active) begin
						next_state = ST_HOLD;
					end else if (tgt_stby && flash_busy) begin
						next_state = ST_FLASH;
					end else if (tgt_stby) begin
						next_state = ST_STBY;
					end else begin
						next_state = ST_SLEEP;
					end
				end
			end
			ST_HOLD: begin
				if (!handler_active) begin
					if (go_stby && flash_busy) begin
						next_state = ST_FLASH;
					end else if (go_stby) begin
						next_state = ST_STBY;
					end else begin
						next_state = ST_SLEEP;
					end
				end
			end
			ST_FLASH: begin
				if (!flash_busy) begin
					next_state = ST_STBY;
				end
			end
			ST_SLEEP: begin
				if (wake) begin
					next_state = ST_WAKE;
				end
			end
			ST_STBY: begin
				if (wake) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// State and the registered clock and power controls, decoded from next_state.
	// reset to run
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_RUN;
			go_stby <= 1'b0;
			wait_is_wfe <= 1'b0;
			core_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			internal_fast_osc_en <= 1'b1;
			external_fast_osc_en <= 1'b1;
			pll_en <= 1'b1;
			regulator_low_power <= 1'b0;
			state_retain <= 1'b0;
			internal_slow_osc_en <= 1'b1;
			watchdog_clk_en <= 1'b1;
			sysclk_to_fast_internal <= 1'b0;
			irq_service_first <= 1'b0;
			awu_event_line9 <= 1'b0;
			low_power_active <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_RUN && wait_instr) begin
				go_stby <= tgt_stby;
				wait_is_wfe <= wait_for_event_instr && !wait_for_interrupt_instr;
			end
			core_clk_en <= (next_state != ST_SLEEP) && (next_state != ST_STBY);
			low_power_active <= (next_state == ST_SLEEP) || (next_state == ST_STBY);
			periph_clk_en <= next_state != ST_STBY;
			internal_fast_osc_en <= next_state != ST_STBY;
			external_fast_osc_en <= next_state != ST_STBY;
			pll_en <= next_state != ST_STBY;
			regulator_low_power <= next_state == ST_STBY;
			state_retain <= next_state == ST_STBY;
			internal_slow_osc_en <= 1'b1;
			watchdog_clk_en <= 1'b1;
			sysclk_to_fast_internal <= (state == ST_STBY) && (next_state == ST_WAKE);
			irq_service_first <= (next_state == ST_WAKE) && irq_accepted;
			awu_event_line9 <= awu_wake;
		end
	end
endmodule
`default_nettype wire

// [core/lpc_defs.vh]
// Constants shared by the low-power mode controller files.
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH

// Register byte addresses on the AXI4-Lite bus.
`define LPC_A_CTRL 32'h40007000
`define LPC_A_STAT 32'h40007004
`define LPC_A_AWCTL 32'h40007008
`define LPC_A_AWWIN 32'h4000700C
`define LPC_A_AWPSC 32'h40007010
`define LPC_A_CFG 32'h40007014
`define LPC_A_MODE 32'h40007018

// Field positions.
`define LPC_B_STBY 1
`define LPC_B_AWEN 1
`define LPC_B_DEEP 0
`define LPC_B_EXIT 1
`define LPC_B_SEVP 2
`define LPC_B_PWEN 3
`define LPC_B_TGT 3

// Field widths.
`define LPC_W_WIN 6
`define LPC_W_PSC 4
`define LPC_W_PCNT 16
`define LPC_W_ST 3

// Reset values.
`define LPC_RST_ZERO 32'h00000000
`define LPC_RST_WIN 6'h3F
`define LPC_RST_PSC 4'h0

// AXI responses.
`define LPC_RESP_OK 2'h0
`define LPC_RESP_ERR 2'h2

`endif

// [core/lpc_sync2.v]
// Two-flop synchroniser for levels that come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module lpc_sync2 #(
	parameter W = 1
) (
	input wire aclk, // System clock.
	input wire aresetn, // Synchronous reset, active low.
	input wire [W-1:0] async_in, // Level from another domain.
	output wire [W-1:0] sync_out // Level safe to read.
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;
	genvar i;
	// Each bit has its own pair; the first stage feeds only the second.
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge aclk) begin
				if (!aresetn) begin
					stage1[i] <= 1'b0;
					stage2[i] <= 1'b0;
				end else begin
					stage1[i] <= async_in[i];
					stage2[i] <= stage1[i];
				end
			end
		end
	endgenerate
	assign sync_out = stage2;
endmodule
`default_nettype wire

// [tb/lpc_controller_properties.sv]
// Port assertions for the low-power mode controller.
`timescale 1ns/1ps
`default_nettype none
module lpc_controller_properties (
	input wire logic aclk, // Clock.
	input wire logic aresetn, // Reset.
	input wire logic s_axi_arvalid, // Read request.
	input wire logic s_axi_arready, // Read ready.
	input wire logic s_axi_rvalid, // Read answer.
	input wire logic wait_for_interrupt_instr, // Wait pulse.
	input wire logic wait_for_event_instr, // Wait pulse.
	input wire logic handler_active, // Handlers busy.
	input wire logic irq_accepted, // Interrupt.
	input wire logic flash_busy, // Flash busy.
	input wire logic core_clk_en, // Core clock.
	input wire logic periph_clk_en, // Peripherals.
	input wire logic internal_fast_osc_en, // Fast osc.
	input wire logic external_fast_osc_en, // Ext osc.
	input wire logic pll_en, // PLL.
	input wire logic regulator_low_power, // Regulator.
	input wire logic state_retain, // Retention.
	input wire logic internal_slow_osc_en, // Slow osc.
	input wire logic watchdog_clk_en, // Watchdog.
	input wire logic sysclk_to_fast_internal, // Clock pulse.
	input wire logic irq_service_first, // Handler pulse.
	input wire logic awu_event_line9, // Timer pulse.
	input wire logic low_power_active // Asleep.
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_run_after_reset: assert property ($rose(aresetn) |-> !low_power_active && core_clk_en)
		else $error("not in run after reset");
	a_sleep_core_only: assert property (low_power_active && !regulator_low_power |->
		!core_clk_en && periph_clk_en && pll_en && internal_fast_osc_en)
		else $error("sleep gated more than the core");
	a_standby_gates: assert property (regulator_low_power |-> !core_clk_en &&
		!periph_clk_en && !pll_en && !internal_fast_osc_en && !external_fast_osc_en
		&& state_retain && low_power_active) else $error("standby gating wrong");
	a_slow_kept: assert property (internal_slow_osc_en && watchdog_clk_en)
		else $error("slow clock or watchdog stopped");
	a_wait_entry: assert property ((wait_for_interrupt_instr || wait_for_event_instr)
		&& core_clk_en && $past(core_clk_en) && !handler_active && !flash_busy
		|=> low_power_active) else $error("wait instruction not taken");
	a_flash_defer: assert property ($rose(regulator_low_power) |-> !$past(flash_busy))
		else $error("standby entered during flash programming");
	a_wake_fast_osc: assert property ($fell(regulator_low_power) |->
		sysclk_to_fast_internal && internal_fast_osc_en && !low_power_active)
		else $error("standby wake without fast clock select");
	a_irq_first: assert property (irq_service_first |->
		$past(irq_accepted) && $past(low_power_active)) else $error("stray handler pulse");
	a_timer_single: assert property (awu_event_line9 |=> !awu_event_line9)
		else $error("timer pulse too long");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	c_sleep: cover property ($rose(low_power_active) && !regulator_low_power);
	c_standby: cover property ($rose(regulator_low_power));
	c_timer: cover property (awu_event_line9);
endmodule
bind lpc_controller lpc_controller_properties u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .wait_for_interrupt_instr(wait_for_interrupt_instr),
	.wait_for_event_instr(wait_for_event_instr), .handler_active(handler_active),
	.irq_accepted(irq_accepted), .flash_busy(flash_busy), .core_clk_en(core_clk_en),
	.periph_clk_en(periph_clk_en), .internal_fast_osc_en(internal_fast_osc_en),
	.external_fast_osc_en(external_fast_osc_en), .pll_en(pll_en),
	.regulator_low_power(regulator_low_power), .state_retain(state_retain),
	.internal_slow_osc_en(internal_slow_osc_en), .watchdog_clk_en(watchdog_clk_en),
	.sysclk_to_fast_internal(sysclk_to_fast_internal), .irq_service_first(irq_service_first),
	.awu_event_line9(awu_event_line9), .low_power_active(low_power_active));
`default_nettype wire

// [tb/lpc_far_model.sv]
// Core and event unit stand-in facing the low-power controller.
`timescale 1ns/1ps
`default_nettype none
module lpc_far_model (
	input wire logic aclk, // Clock.
	input wire logic aresetn, // Reset, active low.
	input wire logic req_wi, // Bench asks for wait-for-interrupt.
	input wire logic req_we, // Bench asks for wait-for-event.
	input wire logic req_pend, // Bench raises a peripheral interrupt.
	input wire logic req_line, // Bench fires an enabled event line.
	input wire logic line9_en, // Line nine trigger enabled.
	input wire logic lp, // Controller asleep.
	input wire logic tmr, // Timer pulse from the controller.
	output logic w_int, // Wait-for-interrupt pulse.
	output logic w_evt, // Wait-for-event pulse.
	output logic pend, // Peripheral pending flag.
	output logic line_wake, // Event unit wake.
	output logic slow_osc // Slow oscillator.
);
	logic lp_d;
	// slow oscillator 128 kHz
	// It free-runs, since the real one never stops in standby.
	initial begin
		slow_osc = 1'b0;
		forever #3906 slow_osc = ~slow_osc;
	end
	// Core pulses and event unit answer one cycle after each request.
	always @(posedge aclk) begin
		lp_d <= lp;
		w_int <= aresetn & req_wi;
		w_evt <= aresetn & req_we;
		line_wake <= aresetn & ((line9_en & tmr) | req_line);
		if (!aresetn || (lp_d && !lp))
			pend <= 1'b0;
		else if (req_pend)
			pend <= 1'b1;
	end
endmodule
`default_nettype wire

// [tb/tb_low_power_mode_controller.sv]
// Self-checking bench for the low-power mode controller.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module tb_low_power_mode_controller;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [1:0] bresp, rresp;
	logic req_wi, req_we, req_pend, req_line, line9_en, w_int, w_evt, pend, line_wake, sosc;
	logic handler, irq, ev, flash, core_en, per_en, fosc_en, eosc_en, pll, reg_lp;
	logic to_fast, svc, tmr, lp;
	logic [33:0] q[$];
	logic [33:0] e;
	logic [15:0] lfsr;
	int n_mismatch, n_tests, cyc, slow_n, tmr_last, n_tmr;
	lpc_controller dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.wait_for_interrupt_instr(w_int), .wait_for_event_instr(w_evt),
		.handler_active(handler), .irq_accepted(irq), .periph_irq_pending(pend),
		.event_line_event(ev), .event_line_wake(line_wake), .flash_busy(flash),
		.internal_slow_osc(sosc), .core_clk_en(core_en), .periph_clk_en(per_en),
		.internal_fast_osc_en(fosc_en), .external_fast_osc_en(eosc_en), .pll_en(pll),
		.regulator_low_power(reg_lp), .state_retain(), .internal_slow_osc_en(),
		.watchdog_clk_en(), .sysclk_to_fast_internal(to_fast), .irq_service_first(svc),
		.awu_event_line9(tmr), .low_power_active(lp));
	lpc_far_model u_far (.aclk(aclk), .aresetn(aresetn), .req_wi(req_wi), .req_we(req_we),
		.req_pend(req_pend), .req_line(req_line), .line9_en(line9_en), .lp(lp), .tmr(tmr),
		.w_int(w_int), .w_evt(w_evt), .pend(pend), .line_wake(line_wake), .slow_osc(sosc));
	// Clock at 125 MHz.
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] nxt(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Write: address and data offered together, each released when taken.
	task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] rs);
		q.push_back({rs, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(logic [31:0] a, logic [31:0] d, logic [1:0] rs);
		q.push_back({rs, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wait_lp(logic v, int lim);
		for (int n = 0; n < lim && lp !== v; n++)
			@(posedge aclk);
		chk("low_power_active", 32'(v), 32'(lp));
	endtask
	task automatic pulse_wait(logic evt);
		req_we <= evt;
		req_wi <= !evt;
		@(posedge aclk);
		req_we <= 1'b0;
		req_wi <= 1'b0;
	endtask
	// Scoreboard: the oldest note meets each bus answer; timer spacing is counted in slow edges.
	always @(posedge sosc)
		slow_n++;
	always @(posedge aclk) begin
		cyc++;
		if (bvalid && bready) begin
			e = q.pop_front();
			chk("bresp", 32'(e[33:32]), 32'(bresp));
		end
		if (rvalid && rready) begin
			e = q.pop_front();
			chk("rresp", 32'(e[33:32]), 32'(rresp));
			chk("rdata", e[31:0], rdata);
		end
		if (tmr === 1'b1) begin
			if (n_tmr > 0) chk("timer_period", 32'((2 + 1) << 1), 32'(slow_n - tmr_last));
			tmr_last = slow_n;
			n_tmr++;
		end
		if (cyc == 40000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, req_wi, req_we, req_pend} = 8'h00;
		{req_line, line9_en, handler, irq, ev, flash} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		lfsr = 16'hDCF4;
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("core_clk_en", 32'h1, 32'(core_en));
		rd(`LPC_A_CTRL, 32'h0, `LPC_RESP_OK);
		rd(`LPC_A_STAT, 32'h0, `LPC_RESP_OK);
		rd(`LPC_A_AWCTL, 32'h0, `LPC_RESP_OK);
		rd(`LPC_A_AWWIN, 32'h3F, `LPC_RESP_OK);
		rd(`LPC_A_AWPSC, 32'h0, `LPC_RESP_OK);
		rd(32'h40007020, 32'h0, `LPC_RESP_ERR);
		wr(`LPC_A_STAT, 32'hFFFFFFFF, `LPC_RESP_ERR);
		wr(`LPC_A_MODE, 32'h0, `LPC_RESP_ERR);
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			wr(`LPC_A_AWWIN, {16'h0, lfsr}, `LPC_RESP_OK);
			rd(`LPC_A_AWWIN, {26'h0, lfsr[5:0]}, `LPC_RESP_OK);
		end
		// Deep sleep off with standby selected still gives sleep; an interrupt wakes it.
		wr(`LPC_A_CTRL, 32'h2, `LPC_RESP_OK);
		pulse_wait(1'b0);
		wait_lp(1'b1, 20);
		chk("periph_clk_en", 32'h1, 32'(per_en));
		irq <= 1'b1;
		wait_lp(1'b0, 20);
		chk("irq_service_first", 32'h1, 32'(svc));
		irq <= 1'b0;
		// Standby is held off by flash programming, then woken by an event line.
		wr(`LPC_A_CFG, 32'h1, `LPC_RESP_OK);
		flash <= 1'b1;
		pulse_wait(1'b1);
		repeat (4) @(posedge aclk);
		chk("low_power_active", 32'h0, 32'(lp));
		rd(`LPC_A_MODE, 32'hA, `LPC_RESP_OK);
		flash <= 1'b0;
		wait_lp(1'b1, 20);
		chk("pll_en", 32'h0, 32'(pll));
		chk("internal_fast_osc_en", 32'h0, 32'(fosc_en));
		chk("external_fast_osc_en", 32'h0, 32'(eosc_en));
		req_line <= 1'b1;
		@(posedge aclk);
		req_line <= 1'b0;
		wait_lp(1'b0, 20);
		chk("sysclk_to_fast_internal", 32'h1, 32'(to_fast));
		// Entry waits for handlers; a peripheral-only interrupt then wakes.
		wr(`LPC_A_CFG, 32'hA, `LPC_RESP_OK);
		handler <= 1'b1;
		pulse_wait(1'b0);
		repeat (4) @(posedge aclk);
		chk("low_power_active", 32'h0, 32'(lp));
		rd(`LPC_A_MODE, 32'h1, `LPC_RESP_OK);
		rd(`LPC_A_CFG, 32'hA, `LPC_RESP_OK);
		handler <= 1'b0;
		wait_lp(1'b1, 20);
		req_pend <= 1'b1;
		@(posedge aclk);
		req_pend <= 1'b0;
		wait_lp(1'b0, 20);
		// Event wait ignores a pending interrupt unless pending-wakes-event is set.
		wr(`LPC_A_CFG, 32'h0, `LPC_RESP_OK);
		pulse_wait(1'b1);
		wait_lp(1'b1, 20);
		req_pend <= 1'b1;
		@(posedge aclk);
		req_pend <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("low_power_active", 32'h1, 32'(lp));
		ev <= 1'b1;
		wait_lp(1'b0, 20);
		ev <= 1'b0;
		wr(`LPC_A_CFG, 32'h4, `LPC_RESP_OK);
		pulse_wait(1'b1);
		wait_lp(1'b1, 20);
		req_pend <= 1'b1;
		@(posedge aclk);
		req_pend <= 1'b0;
		wait_lp(1'b0, 20);
		// Timer wakes standby directly, before line nine fires, then keeps a fixed period.
		wr(`LPC_A_AWWIN, 32'h2, `LPC_RESP_OK);
		wr(`LPC_A_AWPSC, 32'h1, `LPC_RESP_OK);
		wr(`LPC_A_CFG, 32'h1, `LPC_RESP_OK);
		wr(`LPC_A_AWCTL, 32'h2, `LPC_RESP_OK);
		line9_en <= 1'b1;
		pulse_wait(1'b0);
		wait_lp(1'b1, 20);
		wait_lp(1'b0, 8000);
		for (int n = 0; n < 8000 && n_tmr < 2; n++)
			@(posedge aclk);
		chk("timer_pulses", 32'h2, 32'(n_tmr));
		finish_test();
	end
endmodule
`default_nettype wire
